/* File: common/fspo_pkg.sv */
// Shared constants, types and decode helpers for the flash security/protect option block
`default_nettype none
package fspo_pkg;

	// ----------------------------------------
	// Register map (byte addresses, one word each)
	// ----------------------------------------
	localparam int unsigned FSPO_BUS_AW = 4;
	localparam logic [3:0] FSPO_OFS_OPTION = 4'h0;
	localparam logic [3:0] FSPO_OFS_CONFIG = 4'h4;
	localparam logic [3:0] FSPO_OFS_PROTECT = 4'h8;
	localparam logic [3:0] FSPO_OFS_STATUS = 4'hC;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned FSPO_BIT_BACKDOOR_ENABLE = 7;
	localparam int unsigned FSPO_BIT_REDIRECTION_DISABLE = 6;
	localparam int unsigned FSPO_BIT_KEY_WRITE_STEER = 5;
	localparam int unsigned FSPO_BIT_PROTECT_OFF = 0;
	localparam int unsigned FSPO_BIT_VIOL = 0;
	localparam int unsigned FSPO_BIT_SECURE = 1;
	localparam int unsigned FSPO_SEL_W = 7;
	localparam int unsigned FSPO_PAGE_LSB = 9;

	// ----------------------------------------
	// Values and counts
	// ----------------------------------------
	localparam logic [1:0] FSPO_SEC_UNSECURED = 2'h1 << 1;
	localparam logic [7:0] FSPO_OPTION_RST = 8'h00;
	localparam logic [7:0] FSPO_CONFIG_RST = 8'h00;
	localparam logic [7:0] FSPO_PROTECT_RST = 8'h00;
	localparam logic [3:0] FSPO_KEY_BYTES = 4'h8;
	localparam logic [15:0] FSPO_KEY_BASE = 16'hFFB0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		FSPO_BUS_IDLE = 2'h0,
		FSPO_BUS_ACK = 2'h1
	} fspo_bus_e;

	typedef struct packed {
		logic valid;
		logic dbg;
		logic [15:0] addr;
		logic [7:0] data;
	} fspo_fwr_s;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} fspo_cmd_s;

	function automatic logic fspo_is_key_addr(input logic [15:0] addr);
		fspo_is_key_addr = (addr[15:3] == FSPO_KEY_BASE[15:3]);
	endfunction : fspo_is_key_addr

endpackage : fspo_pkg
`default_nettype wire

/* File: design/fspo_key_cmp.sv */
// Backdoor key comparator: eight ordered byte writes checked against the stored key
`timescale 1ns/1ps
`default_nettype none
module fspo_key_cmp (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic steer_i,
	input wire logic wr_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [63:0] key_i,
	output logic unlock_o
);
	import fspo_pkg::*;

	logic steer_d_ff;
	logic [3:0] cnt_ff;
	logic ok_ff;
	logic unlock_ff;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			steer_d_ff <= 1'b0;
		end else begin
			steer_d_ff <= steer_i;
		end
	end

	// Out-of-order or extra bytes poison the attempt until steering is toggled again
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_ff <= 4'h0;
			ok_ff <= 1'b1;
		end else if (steer_i != steer_d_ff) begin
			cnt_ff <= 4'h0;
			ok_ff <= 1'b1;
		end else if (wr_i) begin
			if (wr_idx_i == cnt_ff[2:0] && cnt_ff < FSPO_KEY_BYTES) begin
				cnt_ff <= cnt_ff + 4'h1;
				ok_ff <= ok_ff && (wr_data_i == key_i[{wr_idx_i, 3'b000} +: 8]);
			end else begin
				ok_ff <= 1'b0;
			end
		end
	end

	// Compare is judged when steering drops after the writes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			unlock_ff <= 1'b0;
		end else begin
			unlock_ff <= enable_i && steer_d_ff && !steer_i && ok_ff && cnt_ff == FSPO_KEY_BYTES;
		end
	end

	assign unlock_o = unlock_ff;

endmodule : fspo_key_cmp
`default_nettype wire

/* File: design/fspo_prot_chk.sv */
// Protected-range decode for erase and program targets
`timescale 1ns/1ps
`default_nettype none
module fspo_prot_chk #(
	parameter int unsigned ADDR_W = 16
) (
	input wire logic [7:0] protect_i,
	input wire logic [ADDR_W-1:0] addr_i,
	output logic hit_o
);
	import fspo_pkg::*;

	logic [FSPO_SEL_W-1:0] sel;
	logic [FSPO_SEL_W-1:0] page;

	// Select field sits above the disable bit; pages above it are protected
	always_comb begin
		sel = protect_i[FSPO_SEL_W:1];
		page = addr_i[FSPO_PAGE_LSB +: FSPO_SEL_W];
		hit_o = !protect_i[FSPO_BIT_PROTECT_OFF] && (page > sel);
	end

endmodule : fspo_prot_chk
`default_nettype wire

/* File: design/fspo_top.sv */
// Flash option, security and block-protect control with Avalon-MM register access
//
// Function
// - Reload option register from nonvolatile byte at reset
// - Key enable clear blocks key unlocking
// - Only firmware key writes count, debug ignored
// - Eight ordered matching key bytes unlock
// - Redirection disable bit one disables redirection
// - Security code unsecured only for one-zero
// - Secure state blocks unsecured memory access
// - Key match or blank check sets unsecured
// - Key steering decides key versus command writes
// - Protect register loaded at reset, firmware-read-only
// - Debug commands may rewrite protect register
// - Select field sets high-end protected boundary
// - Refuse erase or program inside region
// - Protect-off bit removes all protection
// - Compare when steering cleared after eight bytes
// - Protected target ignored and violation flag set
`timescale 1ns/1ps
`default_nettype none
module fspo_top #(
	parameter int unsigned ADDR_W = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [fspo_pkg::FSPO_BUS_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic dbg_access_i,
	input wire logic [7:0] option_nonvolatile_byte_i,
	input wire logic [7:0] protect_nonvolatile_byte_i,
	input wire logic [63:0] stored_unlock_key_i,
	input wire fspo_pkg::fspo_fwr_s flash_wr_i,
	input wire fspo_pkg::fspo_cmd_s flash_cmd_i,
	input wire logic blank_ok_i,
	input wire logic unsec_req_i,
	output fspo_pkg::fspo_fwr_s cmd_step_o,
	output logic cmd_go_o,
	output logic cmd_viol_o,
	output logic secure_o,
	output logic redirection_disable_o,
	output logic unsec_grant_o
);
	import fspo_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fspo_bus_e bus_state_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic load_ff;
	logic [7:0] option_working_reg_ff;
	logic [7:0] flash_config_reg_ff;
	logic [7:0] protect_working_reg_ff;
	logic [7:0] nxt_option;
	logic secure_ff;
	logic viol_ff;
	fspo_fwr_s step_ff;
	logic go_ff;
	logic viol_pulse_ff;
	logic grant_ff;
	logic key_unlock;
	logic key_wr;
	logic cmd_hit;
	logic bus_wr;
	logic key_write_steer;
	logic backdoor_enable;

	assign key_write_steer = flash_config_reg_ff[FSPO_BIT_KEY_WRITE_STEER];
	assign backdoor_enable = option_working_reg_ff[FSPO_BIT_BACKDOOR_ENABLE];
	// Write lands at the edge where the master sees waitrequest low
	assign bus_wr = (bus_state_ff == FSPO_BUS_ACK) && avs_write_i;

	// ----------------------------------------
	// Avalon-MM slave handshake
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			bus_state_ff <= FSPO_BUS_IDLE;
			wait_ff <= 1'b1;
		end else begin
			unique case (bus_state_ff)
				FSPO_BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state_ff <= FSPO_BUS_ACK;
						wait_ff <= 1'b0;
					end
				end
				FSPO_BUS_ACK: begin
					bus_state_ff <= FSPO_BUS_IDLE;
					wait_ff <= 1'b1;
				end
			endcase
		end
	end

	// Unmapped offsets read as zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (bus_state_ff == FSPO_BUS_IDLE && avs_read_i) begin
			unique case (avs_address_i)
				FSPO_OFS_OPTION: rdata_ff <= {24'h00_0000, option_working_reg_ff};
				FSPO_OFS_CONFIG: rdata_ff <= {24'h00_0000, flash_config_reg_ff};
				FSPO_OFS_PROTECT: rdata_ff <= {24'h00_0000, protect_working_reg_ff};
				FSPO_OFS_STATUS: rdata_ff <= {30'h0000_0000, secure_ff, viol_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Reset-time load and option word
	// ----------------------------------------
	// Load one cycle after reset so the reset branch only takes constants
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			load_ff <= 1'b1;
		end else begin
			load_ff <= 1'b0;
		end
	end

	// Option word is not writable from the bus; a new byte needs a new reset
	always_comb begin
		nxt_option = option_working_reg_ff;
		if (load_ff) begin
			nxt_option = option_nonvolatile_byte_i;
		end else if (key_unlock || blank_ok_i) begin
			nxt_option[1:0] = FSPO_SEC_UNSECURED;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			option_working_reg_ff <= FSPO_OPTION_RST;
			secure_ff <= 1'b1;
		end else begin
			option_working_reg_ff <= nxt_option;
			secure_ff <= (nxt_option[1:0] != FSPO_SEC_UNSECURED);
		end
	end

	// ----------------------------------------
	// Configuration and protection words
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			flash_config_reg_ff <= FSPO_CONFIG_RST;
		end else if (bus_wr && avs_address_i == FSPO_OFS_CONFIG) begin
			flash_config_reg_ff[FSPO_BIT_KEY_WRITE_STEER] <= avs_writedata_i[FSPO_BIT_KEY_WRITE_STEER];
		end
	end

	// Only the debug path may lift protection; firmware writes vanish
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			protect_working_reg_ff <= FSPO_PROTECT_RST;
		end else if (load_ff) begin
			protect_working_reg_ff <= protect_nonvolatile_byte_i;
		end else if (bus_wr && avs_address_i == FSPO_OFS_PROTECT && dbg_access_i) begin
			protect_working_reg_ff <= avs_writedata_i[7:0];
		end
	end

	// Violation flag: hardware set wins over a same-cycle write-one clear
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			viol_ff <= 1'b0;
		end else if (flash_cmd_i.valid && cmd_hit) begin
			viol_ff <= 1'b1;
		end else if (bus_wr && avs_address_i == FSPO_OFS_STATUS && avs_writedata_i[FSPO_BIT_VIOL]) begin
			viol_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Key-window write steering
	// ----------------------------------------
	// Debug key writes while steering is on are dropped, never compared
	assign key_wr = flash_wr_i.valid && fspo_is_key_addr(flash_wr_i.addr) && key_write_steer && !flash_wr_i.dbg;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			step_ff <= '0;
		end else begin
			step_ff <= flash_wr_i;
			step_ff.valid <= flash_wr_i.valid && !(fspo_is_key_addr(flash_wr_i.addr) && key_write_steer);
		end
	end

	fspo_key_cmp fspo_key_cmp_inst (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.enable_i(backdoor_enable),
		.steer_i(key_write_steer),
		.wr_i(key_wr),
		.wr_idx_i(flash_wr_i.addr[2:0]),
		.wr_data_i(flash_wr_i.data),
		.key_i(stored_unlock_key_i),
		.unlock_o(key_unlock)
	);

	// ----------------------------------------
	// Command gating and access control
	// ----------------------------------------
	fspo_prot_chk #(
		.ADDR_W(ADDR_W)
	) fspo_prot_chk_inst (
		.protect_i(protect_working_reg_ff),
		.addr_i(flash_cmd_i.addr),
		.hit_o(cmd_hit)
	);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			go_ff <= 1'b0;
			viol_pulse_ff <= 1'b0;
		end else begin
			go_ff <= flash_cmd_i.valid && !cmd_hit;
			viol_pulse_ff <= flash_cmd_i.valid && cmd_hit;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			grant_ff <= 1'b0;
		end else begin
			grant_ff <= unsec_req_i && !secure_ff;
		end
	end

	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o = rdata_ff;
	assign cmd_step_o = step_ff;
	assign cmd_go_o = go_ff;
	assign cmd_viol_o = viol_pulse_ff;
	assign secure_o = secure_ff;
	assign redirection_disable_o = option_working_reg_ff[FSPO_BIT_REDIRECTION_DISABLE];
	assign unsec_grant_o = grant_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	AST_LOAD_OPTION: assert property (load_ff |=> option_working_reg_ff == $past(option_nonvolatile_byte_i))
		else $error("option word not loaded after reset");
	AST_NO_KEY_UNLOCK: assert property (!backdoor_enable && !blank_ok_i && !load_ff && secure_ff |=> secure_ff)
		else $error("security lifted with backdoor disabled");
	AST_DBG_KEY_DROP: assert property (flash_wr_i.valid && flash_wr_i.dbg && key_write_steer && $stable(key_write_steer) && fspo_is_key_addr(flash_wr_i.addr) |=> !cmd_step_o.valid && $stable(fspo_key_cmp_inst.cnt_ff))
		else $error("debug key write counted");
	AST_REDIR_LOAD: assert property (load_ff |=> redirection_disable_o == $past(option_nonvolatile_byte_i[6]))
		else $error("redirection bit not taken from option byte");
	AST_SEC_DECODE: assert property (secure_o == (option_working_reg_ff[1:0] != FSPO_SEC_UNSECURED))
		else $error("security decode mismatch");
	AST_GRANT_BLOCK: assert property (secure_ff && !$rose(secure_ff) |=> !unsec_grant_o)
		else $error("unsecured access granted while secure");
	AST_UNSECURE: assert property (key_unlock || (blank_ok_i && !load_ff) |=> !secure_o ##0 option_working_reg_ff[1:0] == FSPO_SEC_UNSECURED)
		else $error("unsecure event did not clear security");
	AST_FWD_STEP: assert property (flash_wr_i.valid && !key_write_steer |=> cmd_step_o.valid && cmd_step_o.addr == $past(flash_wr_i.addr))
		else $error("write not forwarded as command step");
	AST_PROT_RO: assert property (bus_wr && !dbg_access_i && !load_ff |=> $stable(protect_working_reg_ff))
		else $error("protect word changed by firmware");
	AST_PROT_VIOL: assert property (flash_cmd_i.valid && cmd_hit |=> cmd_viol_o && !cmd_go_o && viol_ff)
		else $error("protected command not refused");
	AST_PROT_OFF: assert property (flash_cmd_i.valid && protect_working_reg_ff[FSPO_BIT_PROTECT_OFF] |=> cmd_go_o)
		else $error("command refused with protection off");
	AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && bus_state_ff == FSPO_BUS_IDLE |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle after request");

	COV_KEY_UNLOCK: cover property (key_unlock ##1 !secure_o);
	COV_BLANK_UNLOCK: cover property (secure_o && blank_ok_i ##1 !secure_o);
	COV_VIOLATION: cover property (flash_cmd_i.valid && cmd_hit ##1 cmd_viol_o);
	COV_DBG_PROT_WRITE: cover property (bus_wr && dbg_access_i && avs_address_i == FSPO_OFS_PROTECT);

endmodule : fspo_top
`default_nettype wire

/* File: bench/fspo_host_model.sv */
// Host side model: firmware and background debug master on the Avalon register bus
`timescale 1ns/1ps
`default_nettype none
module fspo_host_model (
	input wire logic core_clk_i,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i,
	output logic [fspo_pkg::FSPO_BUS_AW-1:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	output logic dbg_access_o
);
	import fspo_pkg::*;

	initial begin
		avs_address_o = '0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = '0;
		dbg_access_o = 1'b0;
	end

	// ----------------------------------------
	// One bus transfer; dbg marks a background debug command
	// ----------------------------------------
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic dbg,
		output logic [31:0] q);
		@(posedge core_clk_i);
		avs_address_o <= a;
		avs_writedata_o <= d;
		dbg_access_o <= dbg;
		if (wr) begin
			avs_write_o <= 1'b1;
		end else begin
			avs_read_o <= 1'b1;
		end
		// Hold everything until waitrequest is seen low; only the bench watchdog ends a hang
		do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
		q = avs_readdata_i;
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		dbg_access_o <= 1'b0;
	endtask : xfer
endmodule : fspo_host_model
`default_nettype wire

/* File: bench/flash_security_protect_options_tb.sv */
// Self-checking bench for the flash option, security and protect block
`timescale 1ns/1ps
`default_nettype none
module flash_security_protect_options_tb;
	import fspo_pkg::*;

	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] adr;
	logic rd_s, wr_s, dbg, wq, gnt, sec, rdis, go, viol, blank = 1'b0, ureq = 1'b0;
	logic [31:0] wd, rdat, q;
	logic [7:0] opt = 8'h00, prot = 8'h00;
	logic [63:0] key = 64'h8877_6655_4433_2211;
	fspo_fwr_s fwr = '0, step;
	fspo_cmd_s cmd = '0;
	int fails = 0;
	int n_tests = 0;
	int i;

	fspo_top fspo_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_s),
		.avs_write_i(wr_s), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.dbg_access_i(dbg), .option_nonvolatile_byte_i(opt), .protect_nonvolatile_byte_i(prot),
		.stored_unlock_key_i(key), .flash_wr_i(fwr), .flash_cmd_i(cmd), .blank_ok_i(blank),
		.unsec_req_i(ureq), .cmd_step_o(step), .cmd_go_o(go), .cmd_viol_o(viol), .secure_o(sec),
		.redirection_disable_o(rdis), .unsec_grant_o(gnt));
	fspo_host_model fspo_host_model_inst (.core_clk_i(core_clk_i), .avs_readdata_i(rdat),
		.avs_waitrequest_i(wq), .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s),
		.avs_writedata_o(wd), .dbg_access_o(dbg));

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] exp);
		fspo_host_model_inst.xfer(1'b0, a, 32'h0000_0000, 1'b0, q);
		chk(nm, q, exp);
	endtask : rdc

	task automatic wrb(input logic [3:0] a, input logic [7:0] d, input logic g);
		fspo_host_model_inst.xfer(1'b1, a, {24'h00_0000, d}, g, q);
	endtask : wrb

	task automatic rst_dut(input logic [7:0] o, input logic [7:0] p);
		@(posedge core_clk_i);
		opt <= o;
		prot <= p;
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask : rst_dut

	// Flash-space write pulse; when it ends one cycle later the forwarded command step is already on step
	task automatic fw(input logic [15:0] a, input logic [7:0] d, input logic g);
		@(posedge core_clk_i);
		fwr <= '{1'b1, g, a, d};
		@(posedge core_clk_i);
		fwr <= '0;
		#1;
	endtask : fw

	task automatic fcmd(input logic [15:0] a, input logic eg, input logic ev);
		@(posedge core_clk_i);
		cmd <= '{1'b1, a};
		@(posedge core_clk_i);
		cmd <= '0;
		#1;
		chk("cmd_go", go, eg);
		chk("cmd_viol", viol, ev);
	endtask : fcmd

	task automatic unlock_seq(input logic [7:0] bad);
		wrb(FSPO_OFS_CONFIG, 8'h20, 1'b0);
		for (i = 0; i < 8; i++) begin
			fw(FSPO_KEY_BASE + 16'(i), key[8*i +: 8], 1'b0);
			chk("key_byte_consumed", step.valid, 1'b0);
			// Debug key writes in mid-sequence must neither count nor spoil the attempt
			if (i == 3) fw(FSPO_KEY_BASE + 16'(4), bad, 1'b1);
		end
		wrb(FSPO_OFS_CONFIG, 8'h00, 1'b0);
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : unlock_seq

	initial begin
		#2_000_000;
		fails++;
		stop_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] o;
		for (int c = 0; c < 4; c++) begin
			o = {c[1], c[0], 4'h0, c[1:0]};
			rst_dut(o, 8'hFE);
			chk("secure", sec, (c != 2));
			chk("redir", rdis, c[0]);
			rdc("option", FSPO_OFS_OPTION, {24'h00_0000, o});
		end
		// Secured part with backdoor enabled, top pages protected above page 0x7C
		rst_dut(8'h80, 8'hF8);
		wrb(FSPO_OFS_OPTION, 8'h02, 1'b0);
		rdc("option_ro", FSPO_OFS_OPTION, 32'h0000_0080);
		wrb(FSPO_OFS_PROTECT, 8'h01, 1'b0);
		rdc("prot_fw_wr", FSPO_OFS_PROTECT, 32'h0000_00F8);
		fcmd(16'hFE00, 1'b0, 1'b1);
		fcmd(16'hF9FF, 1'b1, 1'b0);
		rdc("viol_flag", FSPO_OFS_STATUS, 32'h0000_0003);
		wrb(FSPO_OFS_STATUS, 8'h01, 1'b0);
		rdc("viol_clr", FSPO_OFS_STATUS, 32'h0000_0002);
		wrb(FSPO_OFS_PROTECT, 8'hF9, 1'b1);
		rdc("prot_dbg_wr", FSPO_OFS_PROTECT, 32'h0000_00F9);
		fcmd(16'hFFFE, 1'b1, 1'b0);
		fw(16'hFFB2, 8'h5A, 1'b0);
		chk("cmd_step", step, {1'b1, 1'b0, 16'hFFB2, 8'h5A});
		@(posedge core_clk_i);
		ureq <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("grant_secure", gnt, 1'b0);
		unlock_seq(8'h00);
		chk("unlocked", sec, 1'b0);
		rdc("sec_code", FSPO_OFS_OPTION, 32'h0000_0082);
		chk("grant_open", gnt, 1'b1);
		rst_dut(8'h80, 8'hFE);
		chk("relock", sec, 1'b1);
		// Backdoor disabled: a correct key is refused, a blank check still unlocks
		rst_dut(8'h00, 8'hFE);
		unlock_seq(8'h00);
		chk("key_off", sec, 1'b1);
		@(posedge core_clk_i);
		blank <= 1'b1;
		@(posedge core_clk_i);
		blank <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("blank_unlock", sec, 1'b0);
		rdc("blank_code", FSPO_OFS_OPTION, 32'h0000_0002);
		stop_test();
	end
endmodule : flash_security_protect_options_tb
`default_nettype wire
